// File: common/sop_decoder_pkg.sv
package sop_decoder_pkg;

    // ----------------------------------------------------------------------
    // Instruction word layout
    // ----------------------------------------------------------------------
    localparam int WORD_W = 18;
    localparam int OPC_HI = 17;
    localparam int OPC_LO = 13;
    localparam int DEFER_BIT = 12;
    localparam int BIT6_POS = 11;
    localparam int CTRL_HI = 10;
    localparam int CTRL_LO = 6;
    localparam int CLASS_HI = 5;
    localparam int CLASS_LO = 0;
    localparam int SIGN_POS = 17;

    localparam logic [4:0] OPC_SKIP = 5'h1a;
    localparam logic [4:0] OPC_OPERATE = 5'h1f;
    localparam logic [4:0] OPC_INOUT = 5'h1d;

    // ----------------------------------------------------------------------
    // Skip group address bits
    // ----------------------------------------------------------------------
    localparam int SKP_ZERO_ACC = 6;
    localparam int SKP_PLUS_ACC = 7;
    localparam int SKP_MINUS_ACC = 8;
    localparam int SKP_NO_OVF = 9;
    localparam int SKP_PLUS_IO = 10;
    localparam int SEL_SW_HI = 5;
    localparam int SEL_SW_LO = 3;
    localparam int SEL_FLAG_HI = 2;
    localparam int SEL_FLAG_LO = 0;

    // ----------------------------------------------------------------------
    // Operate group address bits
    // ----------------------------------------------------------------------
    localparam int OPR_CLEAR_IO = 11;
    localparam int OPR_OR_SWITCHES = 10;
    localparam int OPR_COMPLEMENT = 9;
    localparam int OPR_HALT = 8;
    localparam int OPR_CLEAR_ACC = 7;
    localparam int OPR_FLAG_SET = 3;

    localparam int NUM_FLAGS = 6;
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_ALL = 3'h7;

    // ----------------------------------------------------------------------
    // Register port map and reset values
    // ----------------------------------------------------------------------
    localparam logic [7:0] REG_ACC = 8'h00;
    localparam logic [7:0] REG_INOUT = 8'h04;
    localparam logic [7:0] REG_PC = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_CONTROL = 8'h10;
    localparam int ST_OVF = 6;
    localparam int ST_HALT = 7;
    localparam int ST_WAIT = 8;
    localparam int ST_PEND = 9;
    localparam int CTL_RUN = 0;
    localparam logic [17:0] WORD_RESET = 18'h00000;
    localparam logic [5:0] FLAGS_RESET = 6'h00;

    typedef enum logic [1:0] {
        RUN_ST = 2'b00,
        WAIT_ST = 2'b01,
        HALT_ST = 2'b10
    } seq_state_type;

endpackage

// File: hdl/skip_operate_inout_decoder.sv
`timescale 1ns/10ps
// How it works
// - Skip group ORs all selected tests, one cycle.
// - Bit 5 set inverts the skip decision.
// - Skip when accumulator is all zero.
// - Skip on plus or minus accumulator sign.
// - Skip on overflow clear; test clears overflow.
// - Overflow set by arithmetic, cleared by start.
// - Skip when in-out register sign is zero.
// - Skip on zero sense switch, or all.
// - Skip on zero program flag, or all.
// - Operate group performs all selected actions together.
// - All-ones word: clear io, load complemented test word, set all flags, halt.
// - Operate clears in-out register.
// - Operate ORs test word switches into accumulator.
// - Operate complements accumulator.
// - Operate clears accumulator.
// - Operate halts after instruction completes.
// - Operate clears chosen flag, or all.
// - Operate sets chosen flag, or all.
// - In-out with bit 5 waits for completion.
// - Completion expected when bit 6 differs from 5.
// - Pure wait word only awaits pending completion.
// - Class and unit control fields go to devices.
module skip_operate_inout_decoder #(
    parameter int ADDR_W = 12
) (
    input wire logic mclk_i, // 250 MHz clock
    input wire logic resetn_i, // async reset, active low
    input wire logic instr_valid_i, // instruction offered
    input wire logic [17:0] instr_i, // instruction word
    output logic instr_ready_o, // instruction may be taken
    input wire logic arith_overflow_i, // arithmetic overflow pulse
    input wire logic [5:0] sense_switches_i, // console sense switches
    input wire logic [17:0] test_word_switches_i, // console test word
    input wire logic start_switch_i, // console start switch
    input wire logic completion_i, // device completion pulse
    input wire logic [7:0] reg_addr_i, // register byte address
    input wire logic [17:0] reg_wdata_i, // register write data
    input wire logic reg_wr_i, // register write strobe
    input wire logic reg_rd_i, // register read strobe
    output logic [17:0] reg_rdata_o, // read data, one cycle later
    output logic [17:0] accumulator_o, // accumulator contents
    output logic [17:0] inout_o, // in-out register contents
    output logic [ADDR_W-1:0] pc_o, // program counter
    output logic [5:0] program_flags_o, // program flags 1 to 6
    output logic overflow_o, // overflow flag
    output logic halted_o, // processor stopped
    output logic skip_o, // skip taken, one-cycle pulse
    output logic iot_pulse_o, // device activate, one-cycle pulse
    output logic [5:0] iot_class_o, // device class of last transfer
    output logic [4:0] iot_control_o, // unit and break control
    output logic completion_pending_o // completion still awaited
);

    // ----------------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------------
    if (ADDR_W < 1 || ADDR_W > 18) begin : g_bad_addr_w
        $error("ADDR_W must lie between 1 and 18");
    end

    // ----------------------------------------------------------------------
    // Console and device input synchronisers
    // ----------------------------------------------------------------------
    logic [25:0] sync_meta, sync_q;
    logic [1:0] edge_prev;
    logic [5:0] sw_sync;
    logic [17:0] tw_sync;
    logic start_sync, comp_sync, start_evt, comp_evt;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync_meta <= 26'h0000000;
            sync_q <= 26'h0000000;
            edge_prev <= 2'h0;
        end else begin
            sync_meta <= {completion_i, start_switch_i,
                          test_word_switches_i, sense_switches_i};
            sync_q <= sync_meta;
            edge_prev <= sync_q[25:24];
        end
    end

    assign {comp_sync, start_sync, tw_sync, sw_sync} = sync_q;
    // Only the rising edge counts, so a held switch acts once.
    assign start_evt = start_sync & ~edge_prev[0];
    assign comp_evt = comp_sync & ~edge_prev[1];

    // ----------------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------------
    logic [17:0] accumulator_reg;
    logic [17:0] inout_reg;
    logic [ADDR_W-1:0] pc_reg;
    logic [5:0] flags;
    logic overflow;
    logic pending;
    sop_decoder_pkg::seq_state_type state, next_state;

    logic take;
    logic [4:0] opc;
    logic defer;
    logic bit6;
    logic is_skip, is_opr, is_iot;
    logic skip_any, skip_taken;
    logic expect_pulse;
    logic must_wait;

    // Zero test of one selected bit, or of all six bits when ALL is chosen.
    function automatic logic sel_is_zero(input logic [5:0] v,
                                         input logic [2:0] s);
        logic r;
        r = 1'b0;
        if (s == sop_decoder_pkg::SEL_ALL) begin
            r = (v == 6'h00);
        end else if (s != sop_decoder_pkg::SEL_NONE) begin
            r = ~v[s - 3'h1];
        end
        return r;
    endfunction

    // Mask of flags touched by a flag selector; zero selects none.
    function automatic logic [5:0] sel_mask(input logic [2:0] s);
        logic [5:0] m;
        m = 6'h00;
        if (s == sop_decoder_pkg::SEL_ALL) begin
            m = 6'h3f;
        end else if (s != sop_decoder_pkg::SEL_NONE) begin
            m[s - 3'h1] = 1'b1;
        end
        return m;
    endfunction

    assign instr_ready_o = (state == sop_decoder_pkg::RUN_ST);
    assign take = instr_valid_i & instr_ready_o;
    assign opc = instr_i[sop_decoder_pkg::OPC_HI:sop_decoder_pkg::OPC_LO];
    assign defer = instr_i[sop_decoder_pkg::DEFER_BIT];
    assign bit6 = instr_i[sop_decoder_pkg::BIT6_POS];
    assign is_skip = take & (opc == sop_decoder_pkg::OPC_SKIP);
    assign is_opr = take & (opc == sop_decoder_pkg::OPC_OPERATE);
    assign is_iot = take & (opc == sop_decoder_pkg::OPC_INOUT);

    always_comb begin
        skip_any = 1'b0;
        if (instr_i[sop_decoder_pkg::SKP_ZERO_ACC] &&
            accumulator_reg == 18'h00000) begin
            skip_any = 1'b1;
        end
        if (instr_i[sop_decoder_pkg::SKP_PLUS_ACC] &&
            !accumulator_reg[sop_decoder_pkg::SIGN_POS]) begin
            skip_any = 1'b1;
        end
        if (instr_i[sop_decoder_pkg::SKP_MINUS_ACC] &&
            accumulator_reg[sop_decoder_pkg::SIGN_POS]) begin
            skip_any = 1'b1;
        end
        if (instr_i[sop_decoder_pkg::SKP_NO_OVF] && !overflow) begin
            skip_any = 1'b1;
        end
        if (instr_i[sop_decoder_pkg::SKP_PLUS_IO] &&
            !inout_reg[sop_decoder_pkg::SIGN_POS]) begin
            skip_any = 1'b1;
        end
        if (sel_is_zero(sw_sync, instr_i[sop_decoder_pkg::SEL_SW_HI:
                                          sop_decoder_pkg::SEL_SW_LO])) begin
            skip_any = 1'b1;
        end
        if (sel_is_zero(flags, instr_i[sop_decoder_pkg::SEL_FLAG_HI:
                                        sop_decoder_pkg::SEL_FLAG_LO])) begin
            skip_any = 1'b1;
        end
    end

    // All tests are evaluated in parallel, so any mix still takes one cycle.
    assign skip_taken = is_skip & (skip_any ^ defer);

    // A pulse comes back only when bit 6 differs from bit 5.
    assign expect_pulse = is_iot & (bit6 != defer);
    // A wait with no pulse outstanding would hang, so it falls through.
    assign must_wait = is_iot & defer &
                       (expect_pulse | pending);

    // ----------------------------------------------------------------------
    // Sequencing
    // ----------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            sop_decoder_pkg::RUN_ST: begin
                if (is_opr && instr_i[sop_decoder_pkg::OPR_HALT]) begin
                    next_state = sop_decoder_pkg::HALT_ST;
                end else if (must_wait) begin
                    next_state = sop_decoder_pkg::WAIT_ST;
                end
            end
            sop_decoder_pkg::WAIT_ST: begin
                // Sequencing resumes on the cycle after the pulse is seen.
                if (comp_evt) begin
                    next_state = sop_decoder_pkg::RUN_ST;
                end
            end
            sop_decoder_pkg::HALT_ST: begin
                if (start_evt || (reg_wr_i &&
                    reg_addr_i == sop_decoder_pkg::REG_CONTROL &&
                    reg_wdata_i[sop_decoder_pkg::CTL_RUN])) begin
                    next_state = sop_decoder_pkg::RUN_ST;
                end
            end
            default: begin
                next_state = sop_decoder_pkg::RUN_ST;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= sop_decoder_pkg::RUN_ST;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------------
    // Program counter
    // ----------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc_reg <= '0;
        end else if (reg_wr_i && reg_addr_i == sop_decoder_pkg::REG_PC) begin
            pc_reg <= reg_wdata_i[ADDR_W-1:0];
        end else if (take) begin
            pc_reg <= pc_reg + (skip_taken ? ADDR_W'(2) : ADDR_W'(1));
        end
    end

    // ----------------------------------------------------------------------
    // Accumulator and in-out register
    // ----------------------------------------------------------------------
    logic [17:0] next_acc;

    always_comb begin
        next_acc = accumulator_reg;
        if (instr_i[sop_decoder_pkg::OPR_CLEAR_ACC]) begin
            next_acc = 18'h00000;
        end
        if (instr_i[sop_decoder_pkg::OPR_OR_SWITCHES]) begin
            next_acc = next_acc | tw_sync;
        end
        if (instr_i[sop_decoder_pkg::OPR_COMPLEMENT]) begin
            next_acc = ~next_acc;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            accumulator_reg <= sop_decoder_pkg::WORD_RESET;
        end else if (reg_wr_i &&
                     reg_addr_i == sop_decoder_pkg::REG_ACC) begin
            accumulator_reg <= reg_wdata_i;
        end else if (is_opr) begin
            accumulator_reg <= next_acc;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            inout_reg <= sop_decoder_pkg::WORD_RESET;
        end else if (reg_wr_i &&
                     reg_addr_i == sop_decoder_pkg::REG_INOUT) begin
            inout_reg <= reg_wdata_i;
        end else if (is_opr && instr_i[sop_decoder_pkg::OPR_CLEAR_IO]) begin
            inout_reg <= sop_decoder_pkg::WORD_RESET;
        end
    end

    // ----------------------------------------------------------------------
    // Program flags
    // ----------------------------------------------------------------------
    logic [5:0] flag_mask;

    assign flag_mask = sel_mask(instr_i[sop_decoder_pkg::SEL_FLAG_HI:
                                        sop_decoder_pkg::SEL_FLAG_LO]);

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flags <= sop_decoder_pkg::FLAGS_RESET;
        end else if (reg_wr_i &&
                     reg_addr_i == sop_decoder_pkg::REG_STATUS) begin
            flags <= reg_wdata_i[5:0];
        end else if (is_opr) begin
            if (instr_i[sop_decoder_pkg::OPR_FLAG_SET]) begin
                flags <= flags | flag_mask;
            end else begin
                flags <= flags & ~flag_mask;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Overflow flag
    // ----------------------------------------------------------------------
    // A new overflow wins over a clear in the same cycle, so none is lost.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            overflow <= 1'b0;
        end else if (arith_overflow_i) begin
            overflow <= 1'b1;
        end else if (start_evt) begin
            overflow <= 1'b0;
        end else if (is_skip && instr_i[sop_decoder_pkg::SKP_NO_OVF]) begin
            overflow <= 1'b0;
        end
    end

    // ----------------------------------------------------------------------
    // In-out transfer control
    // ----------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pending <= 1'b0;
        end else if (expect_pulse) begin
            pending <= 1'b1;
        end else if (comp_evt) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            iot_pulse_o <= 1'b0;
            iot_class_o <= 6'h00;
            iot_control_o <= 5'h00;
        end else begin
            iot_pulse_o <= is_iot;
            if (is_iot) begin
                iot_class_o <= instr_i[sop_decoder_pkg::CLASS_HI:
                                       sop_decoder_pkg::CLASS_LO];
                iot_control_o <= instr_i[sop_decoder_pkg::CTRL_HI:
                                         sop_decoder_pkg::CTRL_LO];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            skip_o <= 1'b0;
        end else begin
            skip_o <= skip_taken;
        end
    end

    // ----------------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 18'h00000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                sop_decoder_pkg::REG_ACC: reg_rdata_o <= accumulator_reg;
                sop_decoder_pkg::REG_INOUT: reg_rdata_o <= inout_reg;
                sop_decoder_pkg::REG_PC: reg_rdata_o <= 18'(pc_reg);
                sop_decoder_pkg::REG_STATUS: begin
                    reg_rdata_o <= {8'h00,
                                    pending,
                                    state == sop_decoder_pkg::WAIT_ST,
                                    state == sop_decoder_pkg::HALT_ST,
                                    overflow,
                                    flags};
                end
                default: reg_rdata_o <= 18'h00000;
            endcase
        end else begin
            reg_rdata_o <= 18'h00000;
        end
    end

    assign accumulator_o = accumulator_reg;
    assign inout_o = inout_reg;
    assign pc_o = pc_reg;
    assign program_flags_o = flags;
    assign overflow_o = overflow;
    assign halted_o = (state == sop_decoder_pkg::HALT_ST);
    assign completion_pending_o = pending;

endmodule

// File: dv/sop_decoder_asserts.sv
`timescale 1ns/10ps
module sop_decoder_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic mclk_i, // clock
    input wire logic resetn_i, // reset
    input wire logic instr_valid_i, // offered
    input wire logic [17:0] instr_i, // word
    input wire logic instr_ready_o, // ready
    input wire logic arith_overflow_i, // adder
    input wire logic completion_i, // device
    input wire logic [17:0] accumulator_o, // acc
    input wire logic [ADDR_W-1:0] pc_o, // pc
    input wire logic overflow_o, // ovf
    input wire logic halted_o, // halted
    input wire logic skip_o, // skip
    input wire logic iot_pulse_o, // activate
    input wire logic completion_pending_o // pending
);
    logic take;
    logic [4:0] opc;
    assign take = instr_valid_i & instr_ready_o;
    assign opc = instr_i[17:13];
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_skp;
        take && opc == sop_decoder_pkg::OPC_SKIP;
    endsequence
    sequence s_opr;
        take && opc == sop_decoder_pkg::OPC_OPERATE;
    endsequence
    sequence s_wait;
        take && opc == sop_decoder_pkg::OPC_INOUT && instr_i[12:11] == 2'b10;
    endsequence
    a_skip_pc_step: assert property (s_skp |=>
        pc_o == ADDR_W'($past(pc_o) + (skip_o ? 2 : 1)))
        else $error("pc step wrong after skip group");
    a_zero_acc_skip: assert property (s_skp ##0
        (!instr_i[12] && instr_i[6] && accumulator_o == 18'h0) |=> skip_o)
        else $error("no skip on zero accumulator");
    a_szo_clears: assert property (s_skp ##0
        (instr_i[9] && !arith_overflow_i) |=> !overflow_o)
        else $error("overflow test left flag set");
    a_ovf_set: assert property (arith_overflow_i |=> overflow_o)
        else $error("overflow not set");
    a_complement_acc: assert property (s_opr ##0
        (instr_i[10:9] == 2'b01 && !instr_i[7])
        |=> accumulator_o == ~$past(accumulator_o))
        else $error("complement wrong");
    a_halt_stops: assert property (s_opr ##0 instr_i[8]
        |=> halted_o && !instr_ready_o)
        else $error("halt not taken");
    a_iot_wait_seq: assert property (s_wait |=>
        (!instr_ready_o && completion_pending_o && iot_pulse_o)
        ##1 !iot_pulse_o)
        else $error("transfer with wait did not suspend");
    a_resume_bound: assert property ($rose(completion_i)
        && completion_pending_o && !halted_o |-> ##[1:5] instr_ready_o)
        else $error("no resume after completion");
endmodule
bind skip_operate_inout_decoder sop_decoder_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// File: dv/completion_device.sv
`timescale 1ns/10ps
module completion_device (
    input wire logic mclk_i, // clock
    input wire logic resetn_i, // reset
    input wire logic iot_pulse_i, // activated
    input wire logic expect_i, // answers this one
    input wire logic [7:0] delay_i, // answer delay
    output logic completion_o // completion pulse
);
    // Three cycles wide, so the decoder's two-stage sync cannot miss it.
    logic [8:0] cnt;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt <= 9'h000;
        end else if (iot_pulse_i && expect_i) begin
            cnt <= {1'b0, delay_i} + 9'h003;
        end else if (cnt != 9'h000) begin
            cnt <= cnt - 9'h001;
        end
    end
    assign completion_o = (cnt != 9'h000) && (cnt <= 9'h003);
endmodule

// File: dv/tb_skip_operate_inout_decoder.sv
`timescale 1ns/10ps
module tb_skip_operate_inout_decoder;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [17:0] instr_i = 18'h0;
    logic arith_overflow_i = 1'b0;
    logic [5:0] sense_switches_i = 6'h0;
    logic [17:0] test_word_switches_i = 18'h0;
    logic start_switch_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h0;
    logic [17:0] reg_wdata_i = 18'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic expect_dev = 1'b0;
    logic [7:0] dev_delay = 8'h0a;
    logic completion_i, instr_ready_o, overflow_o, halted_o, skip_o;
    logic iot_pulse_o, completion_pending_o;
    logic [17:0] reg_rdata_o, accumulator_o, inout_o, m_acc, m_io;
    logic [11:0] pc_o, m_pc;
    logic [5:0] program_flags_o, iot_class_o, m_flags, msk;
    logic [4:0] iot_control_o;
    logic [31:0] r;
    logic m_ovf, m_halt, sk;
    int err_total = 0;
    int n_tests = 0;
    int n;
    skip_operate_inout_decoder #(.ADDR_W(12)) DUT (.*);
    completion_device dev (.mclk_i, .resetn_i, .iot_pulse_i(iot_pulse_o),
        .expect_i(expect_dev), .delay_i(dev_delay),
        .completion_o(completion_i));
    initial forever #2 mclk_i = ~mclk_i;
    task automatic chk(input string what, input logic [17:0] e,
                       input logic [17:0] got);
        n_tests++;
        if (got !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic complete_run();
        $display("mismatches %0d of %0d checks", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [17:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [17:0] e);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 chk("rdata", e, reg_rdata_o);
    endtask
    task automatic issue(input logic [17:0] w);
        @(posedge mclk_i);
        instr_valid_i <= 1'b1;
        instr_i <= w;
        @(posedge mclk_i);
        instr_valid_i <= 1'b0;
        #1;
    endtask
    task automatic wait_ready();
        n = 0;
        while (instr_ready_o !== 1'b1) begin
            @(posedge mclk_i);
            #1 n++;
            if (n > 60) begin
                err_total++;
                complete_run();
            end
        end
    endtask
    function automatic logic [5:0] sel_mask(input logic [2:0] s);
        return s == 3'h7 ? 6'h3f : 6'((7'h01 << s) >> 1);
    endfunction
    task automatic exec(input logic [17:0] w);
        issue(w);
        m_pc = m_pc + 12'h001;
        if (w[17:13] == sop_decoder_pkg::OPC_SKIP) begin
            sk = (w[6] && m_acc == 18'h0) || (w[7] && !m_acc[17]) ||
                (w[8] && m_acc[17]) || (w[9] && !m_ovf) || (w[10] && !m_io[17])
                || (w[5:3] != 3'h0 && (sense_switches_i & sel_mask(w[5:3])) == 0)
                || (w[2:0] != 3'h0 && (m_flags & sel_mask(w[2:0])) == 6'h0);
            sk = sk ^ w[12];
            m_ovf = m_ovf & !w[9];
            m_pc = m_pc + 12'(sk);
            chk("skip", 18'(sk), 18'(skip_o));
        end else begin
            if (w[11]) m_io = 18'h0;
            if (w[7]) m_acc = 18'h0;
            if (w[10]) m_acc = m_acc | test_word_switches_i;
            if (w[9]) m_acc = ~m_acc;
            msk = sel_mask(w[2:0]);
            m_flags = w[3] ? (m_flags | msk) : (m_flags & ~msk);
            m_halt = w[8];
        end
        chk("acc", m_acc, accumulator_o);
        chk("io", m_io, inout_o);
        chk("pc", 18'(m_pc), 18'(pc_o));
        chk("flags", 18'(m_flags), 18'(program_flags_o));
        chk("ovf", 18'(m_ovf), 18'(overflow_o));
        chk("halt", 18'(m_halt), 18'(halted_o));
        if (m_halt) begin
            reg_wr(sop_decoder_pkg::REG_CONTROL, 18'h1);
            m_halt = 1'b0;
        end
    endtask
    initial begin
        void'($urandom(32'hc8a6));
        {m_acc, m_io, m_pc, m_flags, m_ovf, m_halt} = '0;
        repeat (3) @(posedge mclk_i);
        resetn_i <= 1'b1;
        reg_rd(sop_decoder_pkg::REG_STATUS, 18'h0);
        for (int i = 0; i < 80; i++) begin
            r = $urandom;
            @(posedge mclk_i);
            sense_switches_i <= r[5:0] & {6{r[6]}};
            test_word_switches_i <= 18'($urandom);
            arith_overflow_i <= r[7];
            m_ovf = m_ovf | r[7];
            m_acc = 18'($urandom) & {18{r[8]}};
            m_io = 18'($urandom);
            m_flags = r[14:9];
            @(posedge mclk_i);
            arith_overflow_i <= 1'b0;
            reg_wr(sop_decoder_pkg::REG_ACC, m_acc);
            reg_wr(sop_decoder_pkg::REG_INOUT, m_io);
            reg_wr(sop_decoder_pkg::REG_STATUS, {11'h0, m_ovf, m_flags});
            exec({r[15] ? sop_decoder_pkg::OPC_SKIP
                        : sop_decoder_pkg::OPC_OPERATE, r[31:19]});
        end
        for (int k = 0; k < 8; k++) begin
            exec({sop_decoder_pkg::OPC_OPERATE, 10'h0, k[2:0]});
            exec({sop_decoder_pkg::OPC_SKIP, 10'h0, k[2:0]});
            exec({sop_decoder_pkg::OPC_OPERATE, 10'h1, k[2:0]});
            exec({sop_decoder_pkg::OPC_SKIP, 7'h0, k[2:0], 3'h0});
        end
        exec(18'h3ffff);
        arith_overflow_i <= 1'b1;
        @(posedge mclk_i);
        arith_overflow_i <= 1'b0;
        start_switch_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        start_switch_i <= 1'b0;
        #1 chk("ovf", 18'h0, 18'(overflow_o));
        reg_rd(sop_decoder_pkg::REG_STATUS, {12'h0, m_flags});
        reg_rd(sop_decoder_pkg::REG_PC, 18'(m_pc));
        reg_rd(8'h20, 18'h0);
        expect_dev = 1'b1;
        issue({sop_decoder_pkg::OPC_INOUT, 2'b10, 5'h0a, 6'h21});
        chk("ready", 18'h0, 18'(instr_ready_o));
        chk("pend", 18'h1, 18'(completion_pending_o));
        chk("class", 18'h21, 18'(iot_class_o));
        chk("ctrl", 18'h0a, 18'(iot_control_o));
        wait_ready();
        chk("late", 18'h1, 18'(n > 10));
        dev_delay = 8'd20;
        issue({sop_decoder_pkg::OPC_INOUT, 2'b01, 11'h0});
        chk("ready", 18'h1, 18'(instr_ready_o));
        @(posedge mclk_i);
        #1 expect_dev = 1'b0;
        chk("pend", 18'h1, 18'(completion_pending_o));
        issue({sop_decoder_pkg::OPC_INOUT, 2'b11, 11'h0});
        chk("ready", 18'h0, 18'(instr_ready_o));
        wait_ready();
        chk("pend", 18'h0, 18'(completion_pending_o));
        issue({sop_decoder_pkg::OPC_INOUT, 2'b00, 11'h0});
        chk("pend", 18'h0, 18'(completion_pending_o));
        chk("ready", 18'h1, 18'(instr_ready_o));
        complete_run();
    end
endmodule
